/* File: rsm_pkg.sv */
// Purpose: Shared constants, modes and carriers of the rail sequencer and monitor
// Assumes: One 100 MHz clock; configuration is held steady while sequencing
// Notes:   Millisecond count is derived from the clock period
package rsm_pkg;
  localparam int RSM_RAILS   = 8;
  localparam int RSM_GPOS    = 4;
  localparam int RSM_OUTS    = RSM_RAILS + RSM_GPOS;
  localparam int RSM_ADC_W   = 10;
  localparam int RSM_MS_W    = 12;
  localparam int RSM_ADDR_W  = 4;
  localparam int RSM_GPO_PIN = 7;
  localparam int RSM_GPO_IDX = RSM_RAILS;
  localparam int unsigned RSM_CLK_PERIOD_NS = 10;
  localparam int unsigned RSM_MS_NS         = 1000000;
  localparam int unsigned RSM_MS_CYCLES     = RSM_MS_NS / RSM_CLK_PERIOD_NS;
  localparam logic [RSM_MS_W-1:0]   RSM_SHUTDOWN_MAX_MS = 12'hFFF;
  localparam logic [2:0]            RSM_RETRY_MAX       = 3'h4;
  localparam logic [RSM_ADDR_W-1:0] RSM_ADDR_RST        = 4'h0;
  localparam logic [1:0] RSM_LOG_GLITCH  = 2'h0;
  localparam logic [1:0] RSM_LOG_UV      = 2'h1;
  localparam logic [1:0] RSM_LOG_OV      = 2'h2;
  localparam logic [1:0] RSM_LOG_NOSTART = 2'h3;

  typedef enum logic [1:0] {
    SEQ_NONE = 2'h0, SEQ_TIMED = 2'h1, SEQ_PARENT_REG = 2'h2, SEQ_PARENT_THR = 2'h3
  } rsm_seq_e;
  typedef enum logic [2:0] {
    ALM_IGNORE = 3'h0, ALM_LOG = 3'h1, ALM_RETRY_N = 3'h2, ALM_RETRY_CONT = 3'h3,
    ALM_SEQ_NOW = 3'h4, ALM_SEQ_AFTER = 3'h5
  } rsm_alarm_e;
  typedef enum logic [2:0] {
    ST_HOLD = 3'h0, ST_ADDR = 3'h1, ST_CHECK = 3'h2, ST_STORE = 3'h3,
    ST_RUN = 3'h4, ST_KILL = 3'h5
  } rsm_state_e;

  typedef struct packed {
    rsm_seq_e                 mode;
    logic [2:0]               parent;
    logic [RSM_MS_W-1:0]      delay_ms;
    logic [RSM_ADC_W-1:0]     threshold;
    logic [RSM_MS_W-1:0]      shutdown_ms;
    logic                     active_low;
  } rsm_out_cfg_s;
  typedef struct packed {
    logic [RSM_ADC_W-1:0]     undervoltage_limit;
    logic [RSM_ADC_W-1:0]     overvoltage_limit;
    logic [RSM_MS_W-1:0]      glitch_width_limit;
    logic [RSM_MS_W-1:0]      start_time_limit;
    rsm_alarm_e               alarm;
    logic [2:0]               retries;
    logic                     log_flash;
    logic                     ignore_glitch;
    logic [RSM_OUTS-1:0]      dep_mask;
  } rsm_rail_cfg_s;
  typedef struct packed {
    logic                     valid;
    logic [1:0]               kind;
    logic [2:0]               rail;
    logic [RSM_ADC_W-1:0]     volt;
    logic                     flash;
  } rsm_log_s;
endpackage : rsm_pkg

/* File: rsm_top.sv */
// Purpose: Eight-rail power sequencer and monitor with alarm handling
// Assumes: Samples and host commands arrive on CLOCK_I; pins are synchronised here
// Notes:   Configuration checksum and copy storage are done outside, by handshake
`timescale 1ns/1ps
module rsm_top
  import rsm_pkg::*;
#(
  parameter int unsigned MS_CYCLES = RSM_MS_CYCLES
) (
  // Clock and power-on reset
  input  wire logic                                CLOCK_I,
  input  wire logic                                RESET_N_I,
  // Other reset sources
  input  wire logic                                EXT_RESET_N_I,
  input  wire logic                                RESTART_CMD_I,
  // Configuration
  input  wire rsm_out_cfg_s  [RSM_OUTS-1:0]        OUT_CFG_I,
  input  wire rsm_rail_cfg_s [RSM_RAILS-1:0]       RAIL_CFG_I,
  input  wire logic                                EN8_AS_GPO_I,
  input  wire logic                                REF_EXT_SEL_I,
  input  wire logic [RSM_OUTS-1:0]                 SHUTDOWN_CMD_I,
  // Configuration checksum handshake
  input  wire logic                                CFG_CHECK_DONE_I,
  input  wire logic                                CFG_CHECK_OK_I,
  input  wire logic                                CFG_NEW_I,
  input  wire logic                                CFG_STORE_DONE_I,
  // Converter samples
  input  wire logic                                ADC_VALID_I,
  input  wire logic [2:0]                          ADC_CH_I,
  input  wire logic [RSM_ADC_W-1:0]                ADC_DATA_I,
  // Address pins
  input  wire logic [RSM_ADDR_W-1:0]               ADDR_PINS_I,
  // Supply enables and general outputs
  output logic [RSM_RAILS-1:0]                     EN_O,
  output logic [RSM_RAILS-1:0]                     EN_OE_O,
  output logic [RSM_GPOS-1:0]                      GPO_O,
  output logic [RSM_GPOS-1:0]                      GPO_OE_O,
  // Host side status
  output logic                                     HOST_READY_O,
  output logic [RSM_ADDR_W-1:0]                    I2C_ADDR_O,
  output logic [RSM_RAILS-1:0][RSM_ADC_W-1:0]      RAIL_VOLT_O,
  output rsm_log_s                                 LOG_O,
  output logic                                     ADC_REF_EXT_O,
  output logic                                     RESTORE_CFG_O,
  output logic                                     STORE_COPY_O
);
  logic [1:0]                        rst_sync;
  logic                              rst_n;
  logic                              ext_meta, ext_s;
  logic [RSM_ADDR_W-1:0]             addr_meta, addr_s;
  rsm_state_e                        state, next_state;
  logic                              run, tick;
  logic [31:0]                       ms_div;
  logic [RSM_MS_W-1:0]               run_ms;
  logic [RSM_OUTS-1:0]               on, off, kill, kill_set, start_cond, drive, lvl;
  logic [RSM_MS_W-1:0]               sd_cnt  [RSM_OUTS];
  logic [RSM_MS_W-1:0]               reg_cnt [RSM_OUTS];
  logic [RSM_RAILS-1:0]              in_win, started, flt, was_out, retry_off;
  logic [RSM_RAILS-1:0]              sus_evt, glitch_evt, retry_ok, exhaust, act;
  logic [RSM_MS_W-1:0]               st_cnt  [RSM_RAILS];
  logic [RSM_MS_W-1:0]               oow_cnt [RSM_RAILS];
  logic [2:0]                        retry_n [RSM_RAILS];
  logic                              seq_after_pend, seq_after_done, seq_now_evt, reset_req;
  rsm_log_s                          next_log;

  // Reset release, external pin and address pins
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) rst_sync <= 2'h0;
    else            rst_sync <= {rst_sync[0], 1'h1};
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      ext_meta  <= 1'h0;
      ext_s     <= 1'h0;
      addr_meta <= RSM_ADDR_RST;
      addr_s    <= RSM_ADDR_RST;
    end else begin
      ext_meta  <= EXT_RESET_N_I;
      ext_s     <= ext_meta;
      addr_meta <= ADDR_PINS_I;
      addr_s    <= addr_meta;
    end
  end

  // Device reset sequence
  assign run            = (state == ST_RUN);
  assign seq_after_done = seq_after_pend && ((kill & ~off) == '0);
  assign reset_req      = RESTART_CMD_I || seq_now_evt || seq_after_done;

  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD:  if (ext_s) next_state = ST_ADDR;
      ST_ADDR:  next_state = ST_CHECK;
      ST_CHECK: if (CFG_CHECK_DONE_I) next_state = CFG_NEW_I ? ST_STORE : ST_RUN;
      ST_STORE: if (CFG_STORE_DONE_I) next_state = ST_RUN;
      ST_RUN:   if (reset_req) next_state = ST_KILL;
      ST_KILL:  next_state = ST_HOLD;
      default:  next_state = ST_HOLD;
    endcase
    if (!ext_s) next_state = ST_HOLD;
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) state <= ST_HOLD;
    else        state <= next_state;
  end

  // Reset side effects seen by the host and configuration store
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      I2C_ADDR_O    <= RSM_ADDR_RST;
      HOST_READY_O  <= 1'h0;
      RESTORE_CFG_O <= 1'h0;
      STORE_COPY_O  <= 1'h0;
      ADC_REF_EXT_O <= 1'h0;
    end else begin
      if (state == ST_ADDR) I2C_ADDR_O <= addr_s;
      HOST_READY_O  <= (next_state == ST_RUN);
      RESTORE_CFG_O <= (state == ST_CHECK) && CFG_CHECK_DONE_I && !CFG_CHECK_OK_I;
      STORE_COPY_O  <= (next_state == ST_STORE);
      ADC_REF_EXT_O <= REF_EXT_SEL_I;
    end
  end

  // Millisecond tick and time since reset; both held at zero outside RUN
  assign tick = run && (ms_div == MS_CYCLES - 1);
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n)                  ms_div <= 32'h0;
    else if (!run || tick)       ms_div <= 32'h0;
    else                         ms_div <= ms_div + 32'h1;
  end
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n)                                   run_ms <= 12'h0;
    else if (!run)                                run_ms <= 12'h0;
    else if (tick && run_ms != RSM_SHUTDOWN_MAX_MS) run_ms <= run_ms + 12'h1;
  end

  // Monitor samples
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n)           RAIL_VOLT_O <= '0;
    else if (ADC_VALID_I) RAIL_VOLT_O[ADC_CH_I] <= ADC_DATA_I;
  end

  // Sequencing conditions, shared by enables and general outputs
  always_comb begin
    for (int r = 0; r < RSM_RAILS; r++) begin
      in_win[r] = RAIL_VOLT_O[r] >= RAIL_CFG_I[r].undervoltage_limit &&
                  RAIL_VOLT_O[r] <= RAIL_CFG_I[r].overvoltage_limit;
    end
    for (int i = 0; i < RSM_OUTS; i++) begin
      case (OUT_CFG_I[i].mode)
        SEQ_TIMED:      start_cond[i] = run_ms >= OUT_CFG_I[i].delay_ms;
        SEQ_PARENT_REG: start_cond[i] = in_win[OUT_CFG_I[i].parent] &&
                                        reg_cnt[i] >= OUT_CFG_I[i].delay_ms;
        SEQ_PARENT_THR: start_cond[i] = RAIL_VOLT_O[OUT_CFG_I[i].parent] >=
                                        OUT_CFG_I[i].threshold;
        default:        start_cond[i] = 1'h0;
      endcase
      drive[i] = run && on[i] && !off[i] && !(i < RSM_RAILS && retry_off[i % RSM_RAILS]);
      lvl[i]   = drive[i] ^ OUT_CFG_I[i].active_low;
    end
  end

  // Shutdown requests spread down dependency masks one level per cycle
  always_comb begin
    kill_set = SHUTDOWN_CMD_I;
    for (int r = 0; r < RSM_RAILS; r++) begin
      if (kill[r] || exhaust[r]) kill_set = kill_set | RAIL_CFG_I[r].dep_mask;
      if (exhaust[r]) kill_set[r] = 1'h1;
    end
  end

  // Per-output enable, shutdown delay and parent regulation timer
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      on   <= '0;
      off  <= '0;
      kill <= '0;
      for (int i = 0; i < RSM_OUTS; i++) begin
        sd_cnt[i]  <= 12'h0;
        reg_cnt[i] <= 12'h0;
      end
    end else if (!run) begin
      on   <= '0;
      off  <= '0;
      kill <= '0;
      for (int i = 0; i < RSM_OUTS; i++) begin
        sd_cnt[i]  <= 12'h0;
        reg_cnt[i] <= 12'h0;
      end
    end else begin
      kill <= kill | kill_set;
      for (int i = 0; i < RSM_OUTS; i++) begin
        if (start_cond[i]) on[i] <= 1'h1;
        if (!in_win[OUT_CFG_I[i].parent])                reg_cnt[i] <= 12'h0;
        else if (tick && reg_cnt[i] != RSM_SHUTDOWN_MAX_MS) reg_cnt[i] <= reg_cnt[i] + 12'h1;
        if (kill[i] && !off[i]) begin
          if (sd_cnt[i] >= OUT_CFG_I[i].shutdown_ms) off[i] <= 1'h1;
          else if (tick)                              sd_cnt[i] <= sd_cnt[i] + 12'h1;
        end
      end
    end
  end

  // Fault detection and alarm response
  always_comb begin
    seq_now_evt = 1'h0;
    for (int r = 0; r < RSM_RAILS; r++) begin
      act[r]        = drive[r];
      sus_evt[r]    = act[r] && !flt[r] && !in_win[r] &&
                      RAIL_CFG_I[r].alarm != ALM_IGNORE &&
                      (started[r] ? oow_cnt[r] >= RAIL_CFG_I[r].glitch_width_limit
                                  : st_cnt[r] >= RAIL_CFG_I[r].start_time_limit);
      glitch_evt[r] = act[r] && started[r] && in_win[r] && was_out[r] && !flt[r] &&
                      RAIL_CFG_I[r].alarm != ALM_IGNORE;
      retry_ok[r]   = RAIL_CFG_I[r].alarm == ALM_RETRY_CONT ||
                      ((RAIL_CFG_I[r].alarm == ALM_RETRY_N || RAIL_CFG_I[r].alarm == ALM_SEQ_AFTER) &&
                       retry_n[r] < RAIL_CFG_I[r].retries && retry_n[r] < RSM_RETRY_MAX);
      exhaust[r]    = sus_evt[r] && !retry_ok[r] &&
                      (RAIL_CFG_I[r].alarm == ALM_RETRY_N || RAIL_CFG_I[r].alarm == ALM_SEQ_AFTER);
      if (sus_evt[r] && RAIL_CFG_I[r].alarm == ALM_SEQ_NOW) seq_now_evt = 1'h1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      started <= '0;
      flt     <= '0;
      was_out <= '0;
      for (int r = 0; r < RSM_RAILS; r++) begin
        st_cnt[r]  <= 12'h0;
        oow_cnt[r] <= 12'h0;
      end
    end else begin
      for (int r = 0; r < RSM_RAILS; r++) begin
        if (!act[r]) begin
          started[r] <= 1'h0; // Each retry starts a fresh start-time window
          flt[r]     <= 1'h0;
          was_out[r] <= 1'h0;
          st_cnt[r]  <= 12'h0;
          oow_cnt[r] <= 12'h0;
        end else begin
          started[r] <= started[r] || in_win[r];
          was_out[r] <= started[r] && !in_win[r];
          if (sus_evt[r])     flt[r] <= 1'h1;
          else if (in_win[r]) flt[r] <= 1'h0;
          if (tick && !started[r] && st_cnt[r] != RSM_SHUTDOWN_MAX_MS) st_cnt[r] <= st_cnt[r] + 12'h1;
          if (in_win[r])                                    oow_cnt[r] <= 12'h0;
          else if (tick && oow_cnt[r] != RSM_SHUTDOWN_MAX_MS) oow_cnt[r] <= oow_cnt[r] + 12'h1;
        end
      end
    end
  end

  // Retry disables last until the next millisecond tick
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      retry_off      <= '0;
      seq_after_pend <= 1'h0;
      for (int r = 0; r < RSM_RAILS; r++) retry_n[r] <= 3'h0;
    end else if (!run) begin
      retry_off      <= '0;
      seq_after_pend <= 1'h0;
      for (int r = 0; r < RSM_RAILS; r++) retry_n[r] <= 3'h0;
    end else begin
      for (int r = 0; r < RSM_RAILS; r++) begin
        if (sus_evt[r] && retry_ok[r]) begin
          retry_off[r] <= 1'h1;
          if (retry_n[r] != 3'h7) retry_n[r] <= retry_n[r] + 3'h1;
        end else if (tick) begin
          retry_off[r] <= 1'h0;
        end
        if ((kill[r] || exhaust[r]) && RAIL_CFG_I[r].alarm == ALM_SEQ_AFTER) seq_after_pend <= 1'h1;
      end
    end
  end

  // Error log; lowest rail wins when two report in one cycle
  always_comb begin
    next_log = '0;
    for (int r = RSM_RAILS - 1; r >= 0; r--) begin
      if (sus_evt[r] || (glitch_evt[r] && !RAIL_CFG_I[r].ignore_glitch)) begin
        next_log.valid = 1'h1;
        next_log.rail  = 3'(r);
        next_log.volt  = RAIL_VOLT_O[r];
        next_log.flash = RAIL_CFG_I[r].log_flash;
        if (!sus_evt[r])       next_log.kind = RSM_LOG_GLITCH;
        else if (!started[r])  next_log.kind = RSM_LOG_NOSTART;
        else if (RAIL_VOLT_O[r] < RAIL_CFG_I[r].undervoltage_limit) next_log.kind = RSM_LOG_UV;
        else                   next_log.kind = RSM_LOG_OV;
      end
    end
  end
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) LOG_O <= '0;
    else        LOG_O <= next_log;
  end

  // Pins: high impedance in reset, otherwise driven; first general output may use pin 7
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      EN_O     <= '0;
      EN_OE_O  <= '0;
      GPO_O    <= '0;
      GPO_OE_O <= '0;
    end else begin
      EN_OE_O  <= {RSM_RAILS{state != ST_HOLD}};
      GPO_OE_O <= {RSM_GPOS{state != ST_HOLD}} & {{(RSM_GPOS-1){1'h1}}, !EN8_AS_GPO_I};
      EN_O     <= lvl[RSM_RAILS-1:0];
      EN_O[RSM_GPO_PIN] <= EN8_AS_GPO_I ? lvl[RSM_GPO_IDX] : lvl[RSM_GPO_PIN];
      GPO_O    <= lvl[RSM_OUTS-1:RSM_RAILS];
    end
  end

  // Checks
  property p_hiz_in_hold;
    @(posedge CLOCK_I) disable iff (!rst_n) state == ST_HOLD |=> EN_OE_O == '0 && GPO_OE_O == '0;
  endproperty
  a_hiz_in_hold: assert property (p_hiz_in_hold) else $error("outputs driven in reset");

  property p_no_host_in_reset;
    @(posedge CLOCK_I) disable iff (!rst_n) !run ##1 !run |-> !HOST_READY_O;
  endproperty
  a_no_host_in_reset: assert property (p_no_host_in_reset) else $error("host served in reset");

  property p_addr_sample;
    @(posedge CLOCK_I) disable iff (!rst_n) state == ST_ADDR |=> I2C_ADDR_O == $past(addr_s);
  endproperty
  a_addr_sample: assert property (p_addr_sample) else $error("address not sampled");

  property p_restore;
    @(posedge CLOCK_I) disable iff (!rst_n)
      state == ST_CHECK && CFG_CHECK_DONE_I && !CFG_CHECK_OK_I |=> RESTORE_CFG_O;
  endproperty
  a_restore: assert property (p_restore) else $error("bad checksum not restored");

  property p_seq_now;
    @(posedge CLOCK_I) disable iff (!rst_n)
      run && seq_now_evt && ext_s |=> state == ST_KILL ##1 state == ST_HOLD ##1 EN_OE_O == '0;
  endproperty
  a_seq_now: assert property (p_seq_now) else $error("no immediate resequence");

  property p_timers_clear;
    @(posedge CLOCK_I) disable iff (!rst_n) !run |=> run_ms == 12'h0 && on == '0 && ms_div == 32'h0;
  endproperty
  a_timers_clear: assert property (p_timers_clear) else $error("timers survive reset");

  property p_never_seq;
    @(posedge CLOCK_I) disable iff (!rst_n)
      OUT_CFG_I[3].mode == SEQ_NONE && !on[3] && $stable(OUT_CFG_I[3].mode) |=> !on[3];
  endproperty
  a_never_seq: assert property (p_never_seq) else $error("unsequenced output asserted");

  property p_timed_on;
    @(posedge CLOCK_I) disable iff (!rst_n)
      run && next_state == ST_RUN && OUT_CFG_I[0].mode == SEQ_TIMED &&
      run_ms >= OUT_CFG_I[0].delay_ms |=> on[0];
  endproperty
  a_timed_on: assert property (p_timed_on) else $error("timed output late");

  property p_zero_delay_off;
    @(posedge CLOCK_I) disable iff (!rst_n)
      run && next_state == ST_RUN && kill[0] && OUT_CFG_I[0].shutdown_ms == 12'h0 |=> off[0];
  endproperty
  a_zero_delay_off: assert property (p_zero_delay_off) else $error("zero delay shutdown late");

  property p_sustained;
    @(posedge CLOCK_I) disable iff (!rst_n)
      act[2] && started[2] && !flt[2] && !in_win[2] && RAIL_CFG_I[2].alarm != ALM_IGNORE &&
      oow_cnt[2] >= RAIL_CFG_I[2].glitch_width_limit |-> sus_evt[2] ##1 (flt[2] || !act[2]);
  endproperty
  a_sustained: assert property (p_sustained) else $error("sustained fault missed");
endmodule : rsm_top

/* File: rsm_supply_model.sv */
// Purpose: Supply modules behind the enable pins, feeding converter samples
// Assumes: Board pulls each enable to its inactive level
// Notes:   Sag input drops a rail below its window on purpose
`timescale 1ns/1ps
module rsm_supply_model
  import rsm_pkg::*;
(
  // Clock and pins
  input  wire logic                 clk_i,
  input  wire logic [RSM_RAILS-1:0] en_i,
  input  wire logic [RSM_RAILS-1:0] oe_i,
  input  wire logic [RSM_RAILS-1:0] act_low_i,
  input  wire logic [RSM_RAILS-1:0] sag_i,
  // Converter samples
  output logic                      valid_o,
  output logic [2:0]                ch_o,
  output logic [RSM_ADC_W-1:0]      data_o
);
  logic [RSM_RAILS-1:0] on;
  logic [2:0]           nxt;
  // Released pin sits at the pulled inactive level
  assign on = (oe_i & en_i | ~oe_i & act_low_i) ^ act_low_i;
  assign nxt = ch_o + 3'h1;
  initial begin
    valid_o = 1'h0;
    ch_o = 3'h0;
    data_o = '0;
  end
  // Round robin, one channel a cycle
  always @(posedge clk_i) begin
    valid_o <= #1 1'h1;
    ch_o <= #1 nxt;
    data_o <= #1 !on[nxt] ? 10'h000 : sag_i[nxt] ? 10'h064 : 10'h1F4;
  end
endmodule : rsm_supply_model

/* File: tb_top.sv */
// Purpose: Self-checking bench for the rail sequencer and monitor
// Assumes: Short millisecond count; supplies from rsm_supply_model
// Notes:   Expected on-times kept in a table, ms from start of run
`timescale 1ns/1ps
module tb_top;
  import rsm_pkg::*;
  localparam int MS = 10;
  logic clk, rst_n, ext_n, restart, ref_sel, done, ok, nw, ready, restore, store, ref_ext, adc_v;
  logic gpo_sel;
  rsm_log_s log_q, last_log;
  logic [RSM_RAILS-1:0] en, en_oe, sag, al;
  logic [RSM_GPOS-1:0] gpo, gpo_oe;
  logic [RSM_OUTS-1:0] sd_cmd;
  logic [2:0] adc_ch;
  logic [RSM_ADC_W-1:0] adc_d;
  logic [RSM_ADDR_W-1:0] addr, i2c_addr;
  logic [RSM_RAILS-1:0][RSM_ADC_W-1:0] volt;
  rsm_out_cfg_s [RSM_OUTS-1:0] ocfg;
  rsm_rail_cfg_s [RSM_RAILS-1:0] rcfg;
  int on_ms [RSM_OUTS] = '{3, 5, 4, -1, -1, -1, -1, -1, -1, 1, -1, -1};
  int seed, checked, miscompares, cycles, logs, nlog;
  rsm_top #(.MS_CYCLES(MS)) dut_u (
    .CLOCK_I(clk), .RESET_N_I(rst_n), .EXT_RESET_N_I(ext_n), .RESTART_CMD_I(restart),
    .OUT_CFG_I(ocfg), .RAIL_CFG_I(rcfg), .EN8_AS_GPO_I(gpo_sel), .REF_EXT_SEL_I(ref_sel),
    .SHUTDOWN_CMD_I(sd_cmd), .CFG_CHECK_DONE_I(done), .CFG_CHECK_OK_I(ok),
    .CFG_NEW_I(nw), .CFG_STORE_DONE_I(1'h1), .ADC_VALID_I(adc_v), .ADC_CH_I(adc_ch),
    .ADC_DATA_I(adc_d), .ADDR_PINS_I(addr), .EN_O(en), .EN_OE_O(en_oe), .GPO_O(gpo),
    .GPO_OE_O(gpo_oe), .HOST_READY_O(ready), .I2C_ADDR_O(i2c_addr), .RAIL_VOLT_O(volt),
    .LOG_O(log_q), .ADC_REF_EXT_O(ref_ext), .RESTORE_CFG_O(restore), .STORE_COPY_O(store));
  rsm_supply_model sup_u (.clk_i(clk), .en_i(en), .oe_i(en_oe), .act_low_i(al),
    .sag_i(sag), .valid_o(adc_v), .ch_o(adc_ch), .data_o(adc_d));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic wait_ready(input logic lvl, input int lim);
    int n;
    n = 0;
    while (ready !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("ready", ready, lvl);
  endtask : wait_ready
  // Checksum answer held up; only read once the sequencer asks
  task automatic boot(input logic pass, input logic fresh);
    logic rs, st;
    rs = 0;
    st = 0;
    check("no_host", ready, 0);
    ok = pass;
    nw = fresh;
    done = 1'h1;
    for (int n = 0; n < 60 && ready !== 1'h1; n++) begin
      @(posedge clk);
      #1;
      rs |= restore === 1'h1;
      st |= store === 1'h1;
    end
    done = 1'h0;
    check("restore", rs, !pass);
    check("store", st, fresh);
    check("addr", i2c_addr, addr);
    check("oe_run", {gpo_oe, en_oe}, {3'h7, !gpo_sel, 8'hFF});
    $display("test boot done");
  endtask : boot
  task automatic outs(input int t);
    logic lv, on;
    for (int i = 0; i < RSM_OUTS; i++) begin
      lv = (i < RSM_RAILS) ? en[i] : gpo[i-RSM_RAILS];
      on = on_ms[i] >= 0 && on_ms[i] + 2 <= t;
      if (on || on_ms[i] < 0 || on_ms[i] > t)
        check("pin", lv, ocfg[i].active_low ^ on);
    end
  endtask : outs
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  // Log record stands one cycle; count and keep it here
  always @(posedge clk) begin
    if (log_q.valid) begin
      logs <= logs + 1;
      last_log <= log_q;
    end
  end
  initial begin
    {rst_n, restart, done, ok, nw, ocfg, rcfg, sd_cmd, sag, gpo_sel} = '0;
    ext_n = 1'h1;
    seed = 50378;
    addr = $random(seed);
    ref_sel = $random(seed);
    for (int i = 0; i < RSM_OUTS; i++) ocfg[i].active_low = $random(seed);
    // Opposite levels so the shared pin shows which output it carries
    ocfg[8].active_low = !ocfg[7].active_low;
    for (int i = 0; i < RSM_RAILS; i++) begin
      rcfg[i] = '{10'h190, 10'h258, 12'h002, 12'h005, ALM_IGNORE, 3'h0, 1'h0, 1'h0, '0};
      al[i] = ocfg[i].active_low;
    end
    ocfg[0] = '{SEQ_TIMED, 3'h0, 12'h003, 10'h000, 12'h000, al[0]};
    ocfg[1] = '{SEQ_PARENT_REG, 3'h0, 12'h001, 10'h000, 12'h003, al[1]};
    ocfg[2] = '{SEQ_PARENT_THR, 3'h0, 12'h000, 10'h12C, 12'h000, al[2]};
    ocfg[9] = '{SEQ_TIMED, 3'h0, 12'h001, 10'h000, 12'h003, ocfg[9].active_low};
    repeat (3) @(posedge clk);
    #1;
    check("oe_rst", {gpo_oe, en_oe}, 0);
    rst_n = 1'h1;
    boot(1'h1, 1'h0);
    repeat (2 * MS) @(posedge clk);
    #1;
    outs(2);
    repeat (6 * MS) @(posedge clk);
    #1;
    outs(8);
    check("volt0", volt[0], 10'h1F4);
    check("ref", ref_ext, ref_sel);
    $display("test sequencing done");
    sd_cmd[0] = 1'h1;
    sd_cmd[9] = 1'h1;
    @(posedge clk);
    #1;
    sd_cmd = '0;
    repeat (MS) @(posedge clk);
    #1;
    check("sd0", en[0], ocfg[0].active_low);
    check("sd9_wait", gpo[1], !ocfg[9].active_low);
    repeat (4 * MS) @(posedge clk);
    #1;
    check("sd9", gpo[1], ocfg[9].active_low);
    $display("test shutdown done");
    rcfg[2].alarm = ALM_SEQ_NOW;
    sag[2] = 1'h1;
    repeat (MS) @(posedge clk);
    #1;
    check("not_yet", ready, 1);
    check("volt2", volt[2], 10'h064);
    wait_ready(1'h0, 6 * MS);
    check("log", {log_q.valid, log_q.kind, log_q.rail}, {1'h1, RSM_LOG_UV, 3'h2});
    // Levels drop one edge after the host is shut out
    @(posedge clk);
    #1;
    check("no_delay", en[1], ocfg[1].active_low);
    @(posedge clk);
    #1;
    check("oe_kill", {gpo_oe, en_oe}, 0);
    sag = '0;
    rcfg[2].alarm = ALM_IGNORE;
    boot(1'h0, 1'h0);
    $display("test resequence done");
    for (int k = 0; k < 2; k++) begin
      addr = $random(seed);
      gpo_sel = k[0];
      repeat (3) @(posedge clk);
      #1;
      if (k == 0) restart = 1'h1;
      else ext_n = 1'h0;
      @(posedge clk);
      #1;
      restart = 1'h0;
      wait_ready(1'h0, 8);
      ext_n = 1'h1;
      boot(1'h1, k == 0);
      check("pin_share", en[7], gpo_sel ? ocfg[8].active_low : ocfg[7].active_low);
    end
    $display("test restart done");
    // Eight-cycle dip hits channel 2 exactly once, well under the glitch width
    repeat (6 * MS) @(posedge clk);
    #1;
    for (int g = 0; g < 2; g++) begin
      rcfg[2].alarm = ALM_LOG;
      rcfg[2].ignore_glitch = g[0];
      nlog = logs;
      sag[2] = 1'h1;
      repeat (8) @(posedge clk);
      #1;
      sag[2] = 1'h0;
      repeat (30) @(posedge clk);
      #1;
      check("glitch_logs", logs - nlog, !g);
      check("glitch_kind", {last_log.kind, last_log.rail}, {RSM_LOG_GLITCH, 3'h2});
      check("glitch_run", ready, 1);
    end
    $display("test glitch done");
    end_sim();
  end
endmodule : tb_top
